// ===== rtl/crx_consts.svh
// Register offsets, field positions, reset values and limits of the CAN receive-overwrite block.
`ifndef CRX_CONSTS_SVH
`define CRX_CONSTS_SVH

// Register byte offsets on the AHB-Lite slave.
`define CRX_A_CTRL 8'h00
`define CRX_A_STATUS 8'h04
`define CRX_A_BT0 8'h08
`define CRX_A_BT1 8'h0c
`define CRX_A_IRQ_STS 8'h10
`define CRX_A_IRQ_CLR 8'h14
`define CRX_A_IRQ_EN 8'h18
`define CRX_A_CSEL 8'h20
`define CRX_A_CFLAGS 8'h24
`define CRX_A_DATA_LO 8'h28
`define CRX_A_DATA_HI 8'h2c

// Control register bits.
`define CRX_C_SOFT_INIT 0
`define CRX_C_LIMIT_SEL 1
`define CRX_C_ERR_IE 2
`define CRX_C_CAN_IE 3
`define CRX_C_GLB_IE 4

// Status register bits.
`define CRX_S_BUS_OFF 0
`define CRX_S_EXCEEDED 6

// Per-center flag bits.
`define CRX_F_UPD 0
`define CRX_F_IRQ 1
`define CRX_F_TXRQ 2
`define CRX_F_WOE 3
`define CRX_F_ROW 4
`define CRX_F_TXM 5
`define CRX_F_W 6

// Interrupt status, clear and enable bits.
`define CRX_I_ERR 0
`define CRX_I_RX 1
`define CRX_I_LOST 2
`define CRX_I_W 3

// Bit timing field positions.
`define CRX_BT0_PRE_MSB 5
`define CRX_BT0_PHC_LSB 6
`define CRX_BT0_PHC_MSB 7
`define CRX_BT1_T1_MSB 3
`define CRX_BT1_T2_LSB 4
`define CRX_BT1_T2_MSB 6
`define CRX_BT1_SAMP 7

// Error count thresholds, reset values and center numbering.
`define CRX_LIMIT_LO 8'h60
`define CRX_LIMIT_HI 8'h80
`define CRX_RST_BT 8'h00
`define CRX_RST_CTRL 5'h01
`define CRX_CENTERS 15
`define CRX_LAST_CENTER 4'hf

`endif

// ===== rtl/crx_pkg.sv
// Types shared by the CAN receive-overwrite block.
`include "crx_consts.svh"
package crx_pkg;

  // State of the error-count monitor.
  typedef struct packed {
    logic exceeded;
    logic rise;
    logic fall;
  } crx_err_t;

  // State of the top module.
  typedef struct packed {
    logic hreadyout;
    logic [31:0] hrdata;
    logic wr_pend;
    logic [7:0] wr_addr;
    logic [4:0] ctrl;
    logic [7:0] bt0;
    logic [7:0] bt1;
    logic [7:0] act_bt0;
    logic [7:0] act_bt1;
    logic [3:0] center_sel;
    logic [`CRX_CENTERS-1:0][`CRX_F_W-1:0] cflags;
    logic buf_valid;
    logic [63:0] buf_data;
    logic [`CRX_I_W-1:0] irq_sts;
    logic [`CRX_I_W-1:0] irq_en;
    logic irq;
  } crx_top_t;

endpackage

// ===== rtl/crx_msg_mem.sv
// Message storage for the receive centers with one write port and a registered read port.
`timescale 1ns/1ps
module crx_msg_mem #(
  parameter int DEPTH = 16,
  parameter int WIDTH = 64,
  parameter int AW = 4
) (
  input wire logic clk,
  input wire logic we,
  input wire logic [AW-1:0] waddr,
  input wire logic [WIDTH-1:0] wdata,
  input wire logic [AW-1:0] raddr,
  output logic [WIDTH-1:0] rdata
);

  logic [WIDTH-1:0] mem [DEPTH];

  // Array holds no reset; software reads only centers that it has seen updated.
  always_ff @(posedge clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
    rdata <= mem[raddr];
  end

endmodule

// ===== rtl/crx_err_mon.sv
// Compares the transmit and receive error counters against the selected alert threshold.
`timescale 1ns/1ps
`include "crx_consts.svh"
module crx_err_mon
  import crx_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [7:0] tx_cnt,
  input wire logic [7:0] rx_cnt,
  input wire logic limit_sel,
  output logic exceeded,
  output logic rise,
  output logic fall
);

  crx_err_t st_r;
  crx_err_t st_nxt;
  logic [7:0] limit;

  // Threshold follows the select bit at once; going beyond means strictly above.
  always_comb begin
    limit = limit_sel ? `CRX_LIMIT_HI : `CRX_LIMIT_LO; // R8
    st_nxt.exceeded = (tx_cnt > limit) | (rx_cnt > limit); // R9
    st_nxt.rise = st_nxt.exceeded & ~st_r.exceeded;
    st_nxt.fall = ~st_nxt.exceeded & st_r.exceeded;
  end

  // One register stage for the level and its edge pulses.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign exceeded = st_r.exceeded;
  assign rise = st_r.rise;
  assign fall = st_r.fall;

endmodule

// ===== rtl/crx_top.sv
// Receive overwrite, center 15 double buffer, error alerts and bit timing load of a CAN controller.
//
// Overview of operation
// R1 - Unread center's fate for a new message is decided by its write-over enable.
// R2 - Write-over off and unread: drop incoming message, stored message untouched.
// R3 - Write-over on and unread: overwrite data, set receiver-overwrite flag.
// R4 - Center 15 holds two messages; second goes to a hidden buffer.
// R5 - Clearing center 15 update, irq and tx flags moves buffer into memory.
// R6 - Third message to full center 15 with write-over off is discarded.
// R7 - Third message with write-over on replaces the buffered copy only.
// R8 - Limit select picks alert threshold: 96 when 0, 128 when 1.
// R9 - Exceeded bit set while either error counter is above the threshold.
// R10 - Error alert interrupts only with error, CAN and global enables set.
// R11 - With limit select 1, interrupt on both setting and clearing of exceeded.
// R12 - Timing register zero holds phase segment controls and baud prescaler.
// R13 - Timing register one holds sampling control and segment cycle counts.
// R14 - Soft-init falling by software copies both timing registers to active logic.
// R15 - Timing registers writable only in soft-init, not bus-off, out of reset.
// R16 - Software never clears soft-init while both time segment fields are zero.
// R17 - Software programs bit timing before starting the controller.
// R18 - Center 15 only receives, so its handling always concerns incoming messages.
//
// Local design decisions: the register addresses and the AHB-Lite interface to the registers.
`timescale 1ns/1ps
`include "crx_consts.svh"
module crx_top
  import crx_pkg::*;
(
  input wire logic CLK_SYS,
  input wire logic RESET_N,
  input wire logic HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic [2:0] HSIZE,
  input wire logic [31:0] HWDATA,
  input wire logic HREADY,
  output logic HREADYOUT,
  output logic [31:0] HRDATA,
  output logic HRESP,
  input wire logic RX_VALID,
  input wire logic [3:0] RX_CENTER,
  input wire logic [63:0] RX_DATA,
  input wire logic [7:0] TX_ERR_CNT,
  input wire logic [7:0] RX_ERR_CNT,
  input wire logic BUS_OFF,
  output logic IRQ,
  output logic [5:0] ACT_PRESCALER,
  output logic [1:0] ACT_PHASE_CTRL,
  output logic [3:0] ACT_TIME_SEG_ONE,
  output logic [2:0] ACT_TIME_SEG_TWO,
  output logic ACT_SAMPLING
);

  crx_top_t st_r;
  crx_top_t st_nxt;
  logic mem_we;
  logic [3:0] mem_waddr;
  logic [63:0] mem_wdata;
  logic [63:0] mem_rdata;
  logic err_exceeded;
  logic err_rise;
  logic err_fall;

  // Message storage; read address follows the center select register, so data is ready one cycle after the select changes.
  crx_msg_mem #(
    .DEPTH(16),
    .WIDTH(64),
    .AW(4)
  ) u_mem (
    .clk(CLK_SYS),
    .we(mem_we),
    .waddr(mem_waddr),
    .wdata(mem_wdata),
    .raddr(st_r.center_sel),
    .rdata(mem_rdata)
  );

  // Error counter threshold monitor.
  crx_err_mon u_err (
    .clk(CLK_SYS),
    .rst_n(RESET_N),
    .tx_cnt(TX_ERR_CNT),
    .rx_cnt(RX_ERR_CNT),
    .limit_sel(st_r.ctrl[`CRX_C_LIMIT_SEL]),
    .exceeded(err_exceeded),
    .rise(err_rise),
    .fall(err_fall)
  );

  // Next state: bus slave, register writes, reception, buffer move and interrupt.
  always_comb begin
    logic acc;
    logic [3:0] sel_i;
    logic [3:0] rx_i;
    logic [`CRX_F_W-1:0] sel_flags;
    logic [`CRX_F_W-1:0] f;
    logic bt_open;
    logic move;
    logic err_gate;
    logic [`CRX_I_W-1:0] pend;
    acc = 1'b0;
    sel_i = 4'h0;
    rx_i = 4'h0;
    sel_flags = '0;
    f = '0;
    bt_open = 1'b0;
    move = 1'b0;
    err_gate = 1'b0;
    pend = '0;
    st_nxt = st_r;
    mem_we = 1'b0;
    mem_waddr = 4'h0;
    mem_wdata = 64'h0;

    // Address phase; the slave never stalls, so hready out stays high.
    st_nxt.hreadyout = 1'b1;
    acc = HSEL & HTRANS[1] & HREADY;
    st_nxt.wr_pend = acc & HWRITE;
    if (acc) begin
      st_nxt.wr_addr = HADDR[7:0];
    end
    sel_i = st_r.center_sel - 4'h1;
    if (st_r.center_sel != 4'h0) begin
      sel_flags = st_r.cflags[sel_i];
    end

    // Read data is registered at the address phase edge and stands in the data phase.
    if (acc && !HWRITE) begin
      case (HADDR[7:0])
        `CRX_A_CTRL: st_nxt.hrdata = {27'h0, st_r.ctrl};
        `CRX_A_STATUS: begin
          st_nxt.hrdata = 32'h0;
          st_nxt.hrdata[`CRX_S_EXCEEDED] = err_exceeded; // R9
          st_nxt.hrdata[`CRX_S_BUS_OFF] = BUS_OFF;
        end
        `CRX_A_BT0: st_nxt.hrdata = {24'h0, st_r.bt0};
        `CRX_A_BT1: st_nxt.hrdata = {24'h0, st_r.bt1};
        `CRX_A_IRQ_STS: st_nxt.hrdata = {29'h0, st_r.irq_sts};
        `CRX_A_IRQ_EN: st_nxt.hrdata = {29'h0, st_r.irq_en};
        `CRX_A_CSEL: st_nxt.hrdata = {28'h0, st_r.center_sel};
        `CRX_A_CFLAGS: st_nxt.hrdata = {26'h0, sel_flags};
        `CRX_A_DATA_LO: st_nxt.hrdata = mem_rdata[31:0];
        `CRX_A_DATA_HI: st_nxt.hrdata = mem_rdata[63:32];
        default: st_nxt.hrdata = 32'h0;
      endcase
    end

    // Timing registers open only during soft init and away from bus-off.
    bt_open = st_r.ctrl[`CRX_C_SOFT_INIT] & ~BUS_OFF; // R15

    // Data phase of a write; clears happen here so that hardware sets below win.
    if (st_r.wr_pend) begin
      case (st_r.wr_addr)
        `CRX_A_CTRL: begin
          st_nxt.ctrl = HWDATA[4:0];
          if (st_r.ctrl[`CRX_C_SOFT_INIT] && !HWDATA[`CRX_C_SOFT_INIT]) begin
            st_nxt.act_bt0 = st_r.bt0; // R14
            st_nxt.act_bt1 = st_r.bt1; // R14
          end
        end
        `CRX_A_BT0: begin
          if (bt_open) begin
            st_nxt.bt0 = HWDATA[7:0]; // R12
          end
        end
        `CRX_A_BT1: begin
          if (bt_open) begin
            st_nxt.bt1 = HWDATA[7:0]; // R13
          end
        end
        `CRX_A_IRQ_CLR: st_nxt.irq_sts = st_r.irq_sts & ~HWDATA[`CRX_I_W-1:0];
        `CRX_A_IRQ_EN: st_nxt.irq_en = HWDATA[`CRX_I_W-1:0];
        `CRX_A_CSEL: st_nxt.center_sel = HWDATA[3:0];
        `CRX_A_CFLAGS: begin
          if (st_r.center_sel != 4'h0) begin
            st_nxt.cflags[sel_i] = HWDATA[`CRX_F_W-1:0];
          end
        end
        default: st_nxt.cflags = st_nxt.cflags;
      endcase
    end

    // Center 15 is receive only; its transmit mode bit always reads zero.
    st_nxt.cflags[`CRX_CENTERS-1][`CRX_F_TXM] = 1'b0; // R18

    // Buffer move once software has released center 15; it yields the write port to reception.
    f = st_nxt.cflags[`CRX_CENTERS-1];
    move = st_r.buf_valid & ~RX_VALID & ~f[`CRX_F_UPD] & ~f[`CRX_F_IRQ] & ~f[`CRX_F_TXRQ]; // R5
    if (move) begin
      mem_we = 1'b1; // R5
      mem_waddr = `CRX_LAST_CENTER;
      mem_wdata = st_r.buf_data;
      st_nxt.buf_valid = 1'b0;
      st_nxt.cflags[`CRX_CENTERS-1][`CRX_F_UPD] = 1'b1;
      st_nxt.cflags[`CRX_CENTERS-1][`CRX_F_IRQ] = 1'b1;
    end

    // Reception of a message that passed filtering; center 0 does not exist.
    rx_i = RX_CENTER - 4'h1;
    if (RX_VALID && RX_CENTER != 4'h0) begin
      f = st_nxt.cflags[rx_i];
      if (RX_CENTER == `CRX_LAST_CENTER) begin
        if (!f[`CRX_F_UPD] && !st_r.buf_valid) begin
          mem_we = 1'b1;
          mem_waddr = RX_CENTER;
          mem_wdata = RX_DATA;
          f[`CRX_F_UPD] = 1'b1;
          f[`CRX_F_IRQ] = 1'b1;
          st_nxt.irq_sts[`CRX_I_RX] = 1'b1;
        end else if (!st_r.buf_valid) begin
          st_nxt.buf_valid = 1'b1; // R4
          st_nxt.buf_data = RX_DATA; // R4
          st_nxt.irq_sts[`CRX_I_RX] = 1'b1;
        end else if (f[`CRX_F_WOE]) begin
          st_nxt.buf_data = RX_DATA; // R7
          f[`CRX_F_ROW] = 1'b1;
          st_nxt.irq_sts[`CRX_I_RX] = 1'b1;
        end else begin
          st_nxt.irq_sts[`CRX_I_LOST] = 1'b1; // R6
        end
      end else if (!f[`CRX_F_TXM]) begin
        if (f[`CRX_F_UPD] && !f[`CRX_F_WOE]) begin // R1
          st_nxt.irq_sts[`CRX_I_LOST] = 1'b1; // R2
        end else begin
          mem_we = 1'b1;
          mem_waddr = RX_CENTER;
          mem_wdata = RX_DATA;
          if (f[`CRX_F_UPD]) begin
            f[`CRX_F_ROW] = 1'b1; // R3
          end
          f[`CRX_F_UPD] = 1'b1;
          f[`CRX_F_IRQ] = 1'b1;
          st_nxt.irq_sts[`CRX_I_RX] = 1'b1;
        end
      end
      st_nxt.cflags[rx_i] = f;
    end

    // Error alert event; with the high limit the clearing edge counts as well.
    if (err_rise || (err_fall && st_r.ctrl[`CRX_C_LIMIT_SEL])) begin // R11
      st_nxt.irq_sts[`CRX_I_ERR] = 1'b1;
    end

    // The error source also needs its own, the CAN and the global enables.
    err_gate = st_nxt.ctrl[`CRX_C_ERR_IE] & st_nxt.ctrl[`CRX_C_CAN_IE] & st_nxt.ctrl[`CRX_C_GLB_IE]; // R10
    pend = st_nxt.irq_sts & st_nxt.irq_en;
    pend[`CRX_I_ERR] = pend[`CRX_I_ERR] & err_gate; // R10
    st_nxt.irq = |pend;
  end

  // State register; everything starts idle with soft init held.
  always_ff @(posedge CLK_SYS or negedge RESET_N) begin
    if (!RESET_N) begin
      st_r <= '0;
      st_r.hreadyout <= 1'b1;
      st_r.ctrl <= `CRX_RST_CTRL;
      st_r.bt0 <= `CRX_RST_BT;
      st_r.bt1 <= `CRX_RST_BT;
      st_r.act_bt0 <= `CRX_RST_BT;
      st_r.act_bt1 <= `CRX_RST_BT;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Outputs come straight from the state register.
  assign HREADYOUT = st_r.hreadyout;
  assign HRDATA = st_r.hrdata;
  assign HRESP = st_r.wr_pend & 1'b0;
  assign IRQ = st_r.irq;
  assign ACT_PRESCALER = st_r.act_bt0[`CRX_BT0_PRE_MSB:0];
  assign ACT_PHASE_CTRL = st_r.act_bt0[`CRX_BT0_PHC_MSB:`CRX_BT0_PHC_LSB];
  assign ACT_TIME_SEG_ONE = st_r.act_bt1[`CRX_BT1_T1_MSB:0];
  assign ACT_TIME_SEG_TWO = st_r.act_bt1[`CRX_BT1_T2_MSB:`CRX_BT1_T2_LSB];
  assign ACT_SAMPLING = st_r.act_bt1[`CRX_BT1_SAMP];

endmodule

// ===== testbench/crx_props.sv
// Checker for bus answers, timing load, error status and interrupt causes.
`timescale 1ns/1ps
`include "crx_consts.svh"
module crx_props (
  input wire logic CLK_SYS,
  input wire logic RESET_N,
  input wire logic HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic [31:0] HWDATA,
  input wire logic HREADY,
  input wire logic HREADYOUT,
  input wire logic [31:0] HRDATA,
  input wire logic HRESP,
  input wire logic RX_VALID,
  input wire logic [7:0] TX_ERR_CNT,
  input wire logic [7:0] RX_ERR_CNT,
  input wire logic IRQ,
  input wire logic [5:0] ACT_PRESCALER,
  input wire logic [1:0] ACT_PHASE_CTRL,
  input wire logic [3:0] ACT_TIME_SEG_ONE,
  input wire logic [2:0] ACT_TIME_SEG_TWO,
  input wire logic ACT_SAMPLING
);
  default clocking @(posedge CLK_SYS); endclocking
  default disable iff (!RESET_N);
  logic take;
  logic ld;
  logic wr_dp_r;
  logic [7:0] wa_r;
  logic [2:0] hi_r;
  logic [2:0] lo_r;
  logic [2:0] cause_r;
  logic [15:0] cnt_r;
  assign take = HSEL && HTRANS[1] && HREADY;
  assign ld = wr_dp_r && wa_r == `CRX_A_CTRL && !HWDATA[0];
  // Counters saturate, so a long quiet spell never wraps back into range.
  always_ff @(posedge CLK_SYS or negedge RESET_N) begin
    if (!RESET_N) begin
      wr_dp_r <= 1'b0;
      wa_r <= 8'h00;
      hi_r <= 3'h0;
      lo_r <= 3'h0;
      cause_r <= 3'h0;
      cnt_r <= 16'h0000;
    end else begin
      wr_dp_r <= take && HWRITE;
      wa_r <= HADDR[7:0];
      hi_r <= (TX_ERR_CNT > 8'h80 || RX_ERR_CNT > 8'h80) ? hi_r + {2'h0, hi_r != 3'h7} : 3'h0;
      lo_r <= (TX_ERR_CNT <= 8'h60 && RX_ERR_CNT <= 8'h60) ? lo_r + {2'h0, lo_r != 3'h7} : 3'h0;
      cnt_r <= {TX_ERR_CNT, RX_ERR_CNT};
      if (RX_VALID || wr_dp_r || {TX_ERR_CNT, RX_ERR_CNT} != cnt_r) begin
        cause_r <= 3'h0;
      end else begin
        cause_r <= cause_r + {2'h0, cause_r != 3'h7};
      end
    end
  end
  sequence rd_of(logic [7:0] a);
    take && !HWRITE && HADDR[7:0] == a;
  endsequence
  property p_zero(logic [7:0] a);
    rd_of(a) |=> HRDATA == 32'h0;
  endproperty
  a_resp_okay: assert property (HRESP == 1'b0 && HREADYOUT == 1'b1) else $error("bus answer not ready or okay");
  a_unmapped_zero: assert property (p_zero(8'h1c)) else $error("unmapped read not zero");
  a_clear_reads_zero: assert property (p_zero(`CRX_A_IRQ_CLR)) else $error("clear register read not zero");
  a_rdata_hold: assert property (!$stable(HRDATA) |-> $past(take && !HWRITE)) else $error("read data moved");
  a_exceed_set: assert property (rd_of(`CRX_A_STATUS) ##0 hi_r >= 3'h3 |=> HRDATA[6]) else $error("exceed not set");
  a_exceed_clear: assert property (rd_of(`CRX_A_STATUS) ##0 lo_r >= 3'h3 |=> !HRDATA[6]) else $error("exceed stuck");
  a_timing_load: assert property (!$stable({ACT_PRESCALER, ACT_PHASE_CTRL, ACT_TIME_SEG_ONE, ACT_TIME_SEG_TWO,
    ACT_SAMPLING}) |-> $past(ld) || $past(ld, 2)) else $error("timing changed without init exit");
  a_irq_cause: assert property ($rose(IRQ) |-> cause_r <= 3'h5) else $error("interrupt without cause");
endmodule
bind crx_top crx_props u_props (.CLK_SYS(CLK_SYS), .RESET_N(RESET_N), .HSEL(HSEL), .HADDR(HADDR), .HTRANS(HTRANS),
  .HWRITE(HWRITE), .HWDATA(HWDATA), .HREADY(HREADY), .HREADYOUT(HREADYOUT), .HRDATA(HRDATA), .HRESP(HRESP),
  .RX_VALID(RX_VALID), .TX_ERR_CNT(TX_ERR_CNT), .RX_ERR_CNT(RX_ERR_CNT), .IRQ(IRQ), .ACT_PRESCALER(ACT_PRESCALER),
  .ACT_PHASE_CTRL(ACT_PHASE_CTRL), .ACT_TIME_SEG_ONE(ACT_TIME_SEG_ONE), .ACT_TIME_SEG_TWO(ACT_TIME_SEG_TWO),
  .ACT_SAMPLING(ACT_SAMPLING));

// ===== testbench/crx_can_node.sv
// Far-side node model feeding filtered frames, error counters and bus-off.
`timescale 1ns/1ps
module crx_can_node (
  input wire logic clk,
  output logic rx_valid,
  output logic [3:0] rx_center,
  output logic [63:0] rx_data,
  output logic [7:0] tx_cnt,
  output logic [7:0] rx_cnt,
  output logic bus_off
);
  // The line is quiet at time zero.
  initial begin
    rx_valid = 1'b0;
    rx_center = 4'h0;
    rx_data = 64'h0;
    tx_cnt = 8'h00;
    rx_cnt = 8'h00;
    bus_off = 1'b0;
  end
  // A frame is a one-cycle pulse; the data then inverts so stale bytes cannot pass for fresh ones.
  task automatic send(input logic [3:0] c, input logic [63:0] d);
    @(posedge clk);
    rx_valid <= 1'b1;
    rx_center <= c;
    rx_data <= d;
    @(posedge clk);
    rx_valid <= 1'b0;
    rx_center <= 4'h0;
    rx_data <= ~d;
  endtask
  // Counters and bus-off change together, just after an edge.
  task automatic set_line(input logic [7:0] t, input logic [7:0] r, input logic b);
    @(posedge clk);
    tx_cnt <= t;
    rx_cnt <= r;
    bus_off <= b;
  endtask
endmodule

// ===== testbench/test_crx_top.sv
// Self-checking bench for the receive-overwrite block.
`timescale 1ns/1ps
`include "crx_consts.svh"
module test_crx_top;
  logic clk, rst_n, hsel, hwrite, hrdy, hresp, irq, rxv, boff, samp;
  logic [1:0] htrans, phc;
  logic [31:0] haddr, hwdata, hrdata, q;
  logic [3:0] rxc, t1;
  logic [63:0] rxd;
  logic [7:0] txe, rxe;
  logic [5:0] pre;
  logic [2:0] t2;
  int miscompares, n_tests;
  crx_can_node node (.clk(clk), .rx_valid(rxv), .rx_center(rxc), .rx_data(rxd), .tx_cnt(txe), .rx_cnt(rxe),
    .bus_off(boff));
  crx_top uut (.CLK_SYS(clk), .RESET_N(rst_n), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans), .HWRITE(hwrite),
    .HSIZE(3'h2), .HWDATA(hwdata), .HREADY(hrdy), .HREADYOUT(hrdy), .HRDATA(hrdata), .HRESP(hresp),
    .RX_VALID(rxv), .RX_CENTER(rxc), .RX_DATA(rxd), .TX_ERR_CNT(txe), .RX_ERR_CNT(rxe), .BUS_OFF(boff), .IRQ(irq),
    .ACT_PRESCALER(pre), .ACT_PHASE_CTRL(phc), .ACT_TIME_SEG_ONE(t1), .ACT_TIME_SEG_TWO(t2), .ACT_SAMPLING(samp));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic check(input string n, input logic [31:0] s, input logic [31:0] e);
    n_tests++;
    if (s !== e) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", n, e, s);
    end
  endtask
  // One single transfer; the address phase is held until ready is seen, then the data phase likewise.
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'b10;
    hwrite <= w;
    haddr <= {24'h0, a};
    @(posedge clk);
    while (hrdy !== 1'b1) @(posedge clk);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    @(posedge clk);
    while (hrdy !== 1'b1) @(posedge clk);
    q = hrdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input string n);
    bus(1'b0, a, 32'h0);
    check(n, q, e);
  endtask
  // Memory read data lags the store by a registered stage, so give it a few cycles.
  task automatic msg(input logic [63:0] e);
    repeat (3) @(posedge clk);
    rd(`CRX_A_DATA_LO, e[31:0], "data_lo");
    rd(`CRX_A_DATA_HI, e[63:32], "data_hi");
  endtask
  task automatic irqc(input logic e);
    repeat (2) @(posedge clk);
    #1;
    check("irq", {31'h0, irq}, {31'h0, e});
  endtask
  task automatic cnt(input logic [7:0] t, input logic [7:0] r);
    node.set_line(t, r, 1'b0);
    repeat (5) @(posedge clk);
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // Cuts a hang short well past the expected run of a few hundred cycles.
  initial begin
    #100000;
    miscompares++;
    give_verdict();
  end
  initial begin
    {rst_n, hsel, hwrite, htrans, haddr, hwdata, miscompares, n_tests} = '0;
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    rd(`CRX_A_CTRL, 32'h1, "ctrl_rst");
    rd(8'h1c, 32'h0, "unmapped");
    node.set_line(8'h00, 8'h00, 1'b1);
    wr(`CRX_A_BT0, 32'hc5);
    rd(`CRX_A_BT0, 32'h0, "bt0_busoff");
    node.set_line(8'h00, 8'h00, 1'b0);
    wr(`CRX_A_BT0, 32'hc5);
    wr(`CRX_A_BT1, 32'hb3);
    rd(`CRX_A_BT1, 32'hb3, "bt1");
    check("act_early", {26'h0, pre}, 32'h0);
    wr(`CRX_A_CTRL, 32'h1c);
    repeat (2) @(posedge clk);
    check("act_pre", {26'h0, pre}, 32'h5);
    check("act_phc", {30'h0, phc}, 32'h3);
    check("act_seg", {24'h0, samp, t2, t1}, 32'hb3);
    wr(`CRX_A_BT0, 32'h11);
    rd(`CRX_A_BT0, 32'hc5, "bt0_locked");
    wr(`CRX_A_IRQ_EN, 32'h7);
    wr(`CRX_A_CSEL, 32'h3);
    node.send(4'h3, 64'h1111_2222_3333_4444);
    irqc(1'b1);
    rd(`CRX_A_CFLAGS, 32'h3, "flags");
    node.send(4'h3, 64'h5555_6666_7777_8888);
    msg(64'h1111_2222_3333_4444);
    rd(`CRX_A_IRQ_STS, 32'h6, "lost");
    wr(`CRX_A_CFLAGS, 32'hb);
    node.send(4'h3, 64'h9999_aaaa_bbbb_cccc);
    msg(64'h9999_aaaa_bbbb_cccc);
    rd(`CRX_A_CFLAGS, 32'h1b, "row");
    wr(`CRX_A_IRQ_EN, 32'h0);
    irqc(1'b0);
    wr(`CRX_A_IRQ_CLR, 32'h7);
    rd(`CRX_A_IRQ_STS, 32'h0, "sts_clr");
    rd(`CRX_A_IRQ_CLR, 32'h0, "clr_reads_zero");
    wr(`CRX_A_IRQ_EN, 32'h7);
    wr(`CRX_A_CSEL, 32'hf);
    node.send(4'hf, 64'h0a0a_0a0a_0a0a_0a0a);
    node.send(4'hf, 64'h0b0b_0b0b_0b0b_0b0b);
    node.send(4'hf, 64'h0c0c_0c0c_0c0c_0c0c);
    msg(64'h0a0a_0a0a_0a0a_0a0a);
    wr(`CRX_A_CFLAGS, 32'h20);
    msg(64'h0b0b_0b0b_0b0b_0b0b);
    rd(`CRX_A_CFLAGS, 32'h3, "moved");
    wr(`CRX_A_CFLAGS, 32'h0);
    msg(64'h0b0b_0b0b_0b0b_0b0b);
    rd(`CRX_A_CFLAGS, 32'h0, "no_third");
    wr(`CRX_A_CFLAGS, 32'h8);
    node.send(4'hf, 64'h0d0d_0d0d_0d0d_0d0d);
    node.send(4'hf, 64'h0e0e_0e0e_0e0e_0e0e);
    node.send(4'hf, 64'h0f0f_0f0f_0f0f_0f0f);
    msg(64'h0d0d_0d0d_0d0d_0d0d);
    rd(`CRX_A_CFLAGS, 32'h1b, "woe15");
    wr(`CRX_A_CFLAGS, 32'h8);
    msg(64'h0f0f_0f0f_0f0f_0f0f);
    wr(`CRX_A_IRQ_CLR, 32'h7);
    cnt(8'h61, 8'h00);
    rd(`CRX_A_STATUS, 32'h40, "exc96");
    rd(`CRX_A_IRQ_STS, 32'h1, "err_sts");
    irqc(1'b1);
    wr(`CRX_A_IRQ_CLR, 32'h1);
    cnt(8'h60, 8'h00);
    rd(`CRX_A_STATUS, 32'h0, "at96");
    rd(`CRX_A_IRQ_STS, 32'h0, "no_fall");
    wr(`CRX_A_CTRL, 32'h1e);
    cnt(8'h61, 8'h00);
    rd(`CRX_A_STATUS, 32'h0, "exc128");
    cnt(8'h00, 8'h81);
    rd(`CRX_A_STATUS, 32'h40, "rx_exc");
    wr(`CRX_A_CTRL, 32'h16);
    irqc(1'b0);
    wr(`CRX_A_CTRL, 32'h1e);
    irqc(1'b1);
    wr(`CRX_A_IRQ_CLR, 32'h1);
    cnt(8'h00, 8'h00);
    rd(`CRX_A_IRQ_STS, 32'h1, "fall");
    give_verdict();
  end
endmodule
